// ===== include/drive_pkg.sv
package drive_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int MEAS_W = 16;            // Measurement word width
  localparam int CODE_W = 4;             // Function code width
  localparam int NUM_CODES = 16;         // Codes a 4-bit field can hold
  localparam int MON_W = 8;              // Monitor output resolution
  localparam int NUM_THR = 9;            // Threshold registers

  // ==========================================================
  // Output function codes
  // ==========================================================
  localparam logic [3:0] C_RUN = 4'h0;   // Motor running
  localparam logic [3:0] C_SPR = 4'h1;   // Setpoint reached
  localparam logic [3:0] C_ABV = 4'h2;   // Above threshold
  localparam logic [3:0] C_OVL = 4'h3;   // Overload warning
  localparam logic [3:0] C_PID = 4'h4;   // PID deviation
  localparam logic [3:0] C_FLT = 4'h5;   // Fault
  localparam logic [3:0] C_BND = 4'h6;   // In band
  localparam logic [3:0] C_MNL = 4'h8;   // Mains loss
  localparam logic [3:0] C_LSP = 4'h9;   // Low supply
  localparam logic [3:0] C_RNH = 4'hB;   // Run hours
  localparam logic [3:0] C_PWH = 4'hC;   // Power-on hours
  localparam logic [3:0] C_MHT = 4'hD;   // Motor heat

  // ==========================================================
  // Monitor variable codes
  // ==========================================================
  localparam logic [3:0] M_FREQ = 4'h0;  // Output frequency
  localparam logic [3:0] M_CURR = 4'h1;  // Motor current
  localparam logic [3:0] M_TORQ = 4'h2;  // Torque
  localparam logic [3:0] M_FPLS = 4'h3;  // Frequency, pulse form
  localparam logic [3:0] M_VOLT = 4'h4;  // Output voltage
  localparam logic [3:0] M_POWR = 4'h5;  // Input power
  localparam logic [3:0] M_THRM = 4'h6;  // Thermal load ratio
  localparam logic [3:0] M_RAMP = 4'h7;  // Ramp frequency

  // ==========================================================
  // Register byte offsets
  // ==========================================================
  localparam logic [7:0] A_CTRL = 8'h00;   // Relay mode and code
  localparam logic [7:0] A_OSEL = 8'h04;   // Output codes
  localparam logic [7:0] A_THR0 = 8'h08;   // First threshold
  localparam logic [7:0] A_THRN = 8'h28;   // Last threshold
  localparam logic [7:0] A_MSEL = 8'h2C;   // Monitor codes
  localparam logic [7:0] A_FLAG = 8'h30;   // Live flags
  localparam logic [7:0] A_ISTA = 8'h34;   // Sticky status
  localparam logic [7:0] A_IMSK = 8'h38;   // Interrupt mask
  localparam logic [7:0] A_OUTS = 8'h3C;   // Output state

  // Threshold indices
  localparam int T_FREQ = 0;   // Frequency threshold
  localparam int T_BLO = 1;    // Band lower edge
  localparam int T_BHI = 2;    // Band upper edge
  localparam int T_TOL = 3;    // Frequency tolerance
  localparam int T_OVL = 4;    // Overload threshold
  localparam int T_PID = 5;    // Permissible deviation
  localparam int T_RUN = 6;    // Run hours limit
  localparam int T_ON = 7;     // Power-on hours limit
  localparam int T_THM = 8;    // Thermal warning threshold

  // Field positions and reset values
  localparam int CTRL_MODE_BIT = 0;                 // 1: relay programmable
  localparam int CTRL_CODE_LSB = 4;                 // Relay function code
  localparam logic [7:0] CTRL_RST = 8'h50;          // Fault mode, code fault
  localparam logic [3:0] OSEL_RST = 4'hF;           // Unsupported code
  localparam logic [15:0] THR_RST = 16'h0000;       // Thresholds
  localparam logic [11:0] MSEL_RST = 12'h000;       // Monitors on frequency
  localparam logic [15:0] MASK_RST = 16'h0000;      // All masked

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic [MEAS_W-1:0] fout;       // Output frequency
    logic [MEAS_W-1:0] fset;       // Setpoint frequency
    logic [MEAS_W-1:0] ramp;       // Ramp frequency
    logic [MEAS_W-1:0] current;    // Motor current
    logic [MEAS_W-1:0] torque;     // Torque
    logic [MEAS_W-1:0] volt;       // Output voltage
    logic [MEAS_W-1:0] power;      // Input power
    logic [MEAS_W-1:0] load;       // Measured load
    logic [MEAS_W-1:0] pid_err;    // PID error magnitude
    logic [MEAS_W-1:0] thermal;    // Motor thermal load
    logic [MEAS_W-1:0] run_hours;  // Accumulated run time
    logic [MEAS_W-1:0] on_hours;   // Accumulated on time
  } drive_meas_t;

  typedef struct packed {
    logic motor_run;   // Motor operated
    logic fault;       // Fault present
    logic mains_dip;   // Brief mains interruption
    logic undervolt;   // Undervoltage
  } drive_pins_t;

  localparam int PIN_W = $bits(drive_pins_t);  // Pin group width

endpackage : drive_pkg

// ===== hdl/sync2.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Two-stage synchroniser for asynchronous levels
// ============================================================
module sync2 #(
  parameter int W = 1                 // Bits synchronised
) (
  input  wire logic         clk,      // Clock
  input  wire logic         rst_n,    // Async reset, low
  input  wire logic [W-1:0] d,        // Async levels
  output logic      [W-1:0] q         // Synchronised levels
);

  logic [W-1:0] meta_q;               // First stage, read by q only

  // Two flops in series
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : sync2

`default_nettype wire

// ===== hdl/monitor_sel.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Monitor output variable selection
// ============================================================
module monitor_sel (
  input  wire logic                        clk,    // Clock
  input  wire logic                        rst_n,  // Async reset, low
  input  wire logic [drive_pkg::CODE_W-1:0] code,  // Variable code
  input  wire drive_pkg::drive_meas_t      meas,   // Measurements
  output logic [drive_pkg::MON_W-1:0]      mon_q   // Selected, top bits
);

  logic [drive_pkg::MEAS_W-1:0] pick;   // Selected variable

  // Variable mux; unknown codes give zero
  assign pick = (code == drive_pkg::M_FREQ) ? meas.fout    :
                (code == drive_pkg::M_FPLS) ? meas.fout    :
                (code == drive_pkg::M_CURR) ? meas.current :
                (code == drive_pkg::M_TORQ) ? meas.torque  :
                (code == drive_pkg::M_VOLT) ? meas.volt    :
                (code == drive_pkg::M_POWR) ? meas.power   :
                (code == drive_pkg::M_THRM) ? meas.thermal :
                (code == drive_pkg::M_RAMP) ? meas.ramp    : '0;

  // Register the upper bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mon_q <= '0;
    else        mon_q <= pick[drive_pkg::MEAS_W-1 -: drive_pkg::MON_W];
  end

endmodule : monitor_sel

`default_nettype wire

// ===== hdl/drive_status_output_select.sv
// Operation
// - Code 00 asserts output while motor runs
// - Code 01 asserts while setpoint frequency reached
// - Code 02 asserts while frequency exceeds threshold
// - Code 03 asserts while load exceeds threshold
// - Code 04 asserts while PID error too large
// - Code 05 asserts while a fault exists
// - Code 06 asserts while frequency in band
// - Code 8 asserts on mains interruption
// - Code 9 asserts during undervoltage
// - Code 11 asserts past run-hours limit
// - Code 12 asserts past power-on-hours limit
// - Code 13 asserts past motor thermal threshold
// - Healthy contact closed unless fault or unpowered, in fault mode
// - Fault relay usable as programmable output
// - Each monitor selects one drive variable
`timescale 1ns/10ps
`default_nettype none

module drive_status_output_select #(
  parameter int N_OUT = 2                        // Programmable relays
) (
  input  wire logic                   pclk,      // APB clock
  input  wire logic                   presetn,   // Async reset, low
  input  wire logic                   psel,      // APB select
  input  wire logic                   penable,   // APB enable
  input  wire logic                   pwrite,    // APB write
  input  wire logic [7:0]             paddr,     // APB byte address
  input  wire logic [31:0]            pwdata,    // APB write data
  output logic      [31:0]            prdata,    // APB read data
  output logic                        pready,    // APB ready
  output logic                        pslverr,   // APB error
  input  wire drive_pkg::drive_pins_t pins,      // Async drive levels
  input  wire drive_pkg::drive_meas_t meas,      // Same-clock values
  output logic      [N_OUT-1:0]       relay_out, // Programmable relays
  output logic                        relay_healthy_contact, // Healthy
  output logic                        relay_fault_contact,   // Fault
  output logic      [7:0]             voltage_monitor_out,   // Monitor
  output logic      [7:0]             current_monitor_out,   // Monitor
  output logic      [7:0]             pulse_monitor_out,     // Monitor
  output logic                        irq        // Interrupt, high
);

  // Short names for package widths
  localparam int MW = drive_pkg::MEAS_W;  // Value width
  localparam int NC = drive_pkg::NUM_CODES; // Flag vector width

  // ==========================================================
  // Elaboration check
  // ==========================================================
  // Codes pack four bits each into one word
  if (N_OUT < 1 || N_OUT > 8) begin : g_bad_n
    $error("N_OUT must be 1 to 8");
  end

  // Flag selection by function code
  // Codes without a condition read a zero bit
  function automatic logic sel_flag(input logic [NC-1:0] f,
                                    input logic [3:0] c);
    sel_flag = f[c];
  endfunction : sel_flag

  // ==========================================================
  // Registers
  // ==========================================================
  // Software-visible state, async reset
  logic [7:0]          ctrl_q;            // Relay mode and code
  logic [4*N_OUT-1:0]  osel_q;            // Output codes
  logic [MW-1:0]       thr_q [drive_pkg::NUM_THR]; // Thresholds
  logic [11:0]         msel_q;            // Monitor codes
  logic [NC-1:0]       ista_q;            // Sticky events
  logic [NC-1:0]       imsk_q;            // Interrupt mask
  logic [NC-1:0]       flag_q;            // Live flags
  drive_pkg::drive_pins_t pin_s;          // Synchronised pins

  // ==========================================================
  // APB decode
  // ==========================================================
  // A transfer completes when ready is seen
  wire acc      = psel & penable;                 // Access phase
  wire fire     = acc & pready;                   // Completing edge
  wire wr_fire  = fire & pwrite;                  // Write commits
  wire hit_ctrl = paddr == drive_pkg::A_CTRL;     // Control
  wire hit_osel = paddr == drive_pkg::A_OSEL;     // Output codes
  // Thresholds fill a window of aligned words
  wire hit_thr  = paddr >= drive_pkg::A_THR0 && paddr <= drive_pkg::A_THRN
                  && paddr[1:0] == 2'b00;         // Threshold window
  wire hit_msel = paddr == drive_pkg::A_MSEL;     // Monitor codes
  wire hit_flag = paddr == drive_pkg::A_FLAG;     // Flags, read only
  wire hit_ista = paddr == drive_pkg::A_ISTA;     // Status
  wire hit_imsk = paddr == drive_pkg::A_IMSK;     // Mask
  wire hit_outs = paddr == drive_pkg::A_OUTS;     // Output state
  wire hit_any  = (hit_ctrl | hit_osel | hit_thr | hit_msel | hit_flag
                   | hit_ista | hit_imsk | hit_outs) & paddr[1:0] == 2'b00;
  // Index from the offset into the window
  wire [7:0] thr_off = paddr - drive_pkg::A_THR0; // Window offset
  wire [3:0] thr_idx = thr_off[5:2];              // Threshold index

  // Read mux; unmapped addresses read zero
  wire [31:0] rd_data =
      hit_ctrl ? {24'h000000, ctrl_q} :
      hit_osel ? 32'(osel_q) :
      hit_thr  ? 32'(thr_q[thr_idx]) :
      hit_msel ? {20'h00000, msel_q} :
      hit_flag ? 32'(flag_q) :
      hit_ista ? 32'(ista_q) :
      hit_imsk ? 32'(imsk_q) :
      hit_outs ? 32'({relay_fault_contact, relay_healthy_contact,
                      relay_out}) : 32'h00000000;

  // One wait state: ready is high in the second access cycle
  // Read data and error are launched with ready, so they
  // stand only in the cycle that the master samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      prdata  <= (acc & ~pready & ~pwrite) ? rd_data : 32'h00000000;
      pslverr <= acc & ~pready & ~hit_any;
    end
  end

  // Configuration written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= drive_pkg::CTRL_RST;
      osel_q <= {N_OUT{drive_pkg::OSEL_RST}};
      msel_q <= drive_pkg::MSEL_RST;
      imsk_q <= drive_pkg::MASK_RST;
    end else if (wr_fire) begin
      if (hit_ctrl) ctrl_q <= pwdata[7:0];
      if (hit_osel) osel_q <= pwdata[4*N_OUT-1:0];
      if (hit_msel) msel_q <= pwdata[11:0];
      if (hit_imsk) imsk_q <= pwdata[NC-1:0];
    end
  end

  // Threshold storage
  // Reset clears every threshold to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < drive_pkg::NUM_THR; i++) thr_q[i] <= drive_pkg::THR_RST;
    end else if (wr_fire && hit_thr) begin
      thr_q[thr_idx] <= pwdata[MW-1:0];
    end
  end

  // ==========================================================
  // Condition evaluation
  // ==========================================================
  // Asynchronous drive levels pass two flops
  sync2 #(.W(drive_pkg::PIN_W)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pins),
    .q     (pin_s)
  );

  // One tolerance serves setpoint and band checks; the low
  // band edge saturates at zero so it cannot wrap
  wire [MW-1:0] tol   = thr_q[drive_pkg::T_TOL];             // Tolerance
  wire [MW-1:0] fdiff = (meas.fout >= meas.fset) ? meas.fout - meas.fset
                                                 : meas.fset - meas.fout;
  wire [MW-1:0] blo   = (thr_q[drive_pkg::T_BLO] > tol)
                        ? thr_q[drive_pkg::T_BLO] - tol : '0; // Low edge
  wire [MW:0]   bhi   = {1'b0, thr_q[drive_pkg::T_BHI]} + {1'b0, tol};

  logic [NC-1:0] flag_d;   // Condition vector indexed by code

  // Unused codes stay zero
  // Bit position equals the code it serves
  always_comb begin
    flag_d = '0;
    flag_d[drive_pkg::C_RUN] = pin_s.motor_run;
    flag_d[drive_pkg::C_SPR] = fdiff <= tol;
    flag_d[drive_pkg::C_ABV] = meas.fout > thr_q[drive_pkg::T_FREQ];
    flag_d[drive_pkg::C_OVL] = meas.load > thr_q[drive_pkg::T_OVL];
    flag_d[drive_pkg::C_PID] = meas.pid_err > thr_q[drive_pkg::T_PID];
    flag_d[drive_pkg::C_FLT] = pin_s.fault;
    flag_d[drive_pkg::C_BND] = meas.fout >= blo
                               && {1'b0, meas.fout} <= bhi;
    flag_d[drive_pkg::C_MNL] = pin_s.mains_dip;
    flag_d[drive_pkg::C_LSP] = pin_s.undervolt;
    flag_d[drive_pkg::C_RNH] = meas.run_hours > thr_q[drive_pkg::T_RUN];
    flag_d[drive_pkg::C_PWH] = meas.on_hours > thr_q[drive_pkg::T_ON];
    flag_d[drive_pkg::C_MHT] = meas.thermal > thr_q[drive_pkg::T_THM];
  end

  // Flags re-evaluated every cycle
  // No latching: a flag falls a cycle after its condition, three cycles after a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_q <= '0;
    else          flag_q <= flag_d;
  end

  // ==========================================================
  // Relay outputs
  // ==========================================================
  // Mode bit picks fault signalling or a code
  wire       relay_prog = ctrl_q[drive_pkg::CTRL_MODE_BIT];          // Mode
  wire [3:0] relay_code = ctrl_q[drive_pkg::CTRL_CODE_LSB +: 4];     // Code
  wire       healthy_d  = relay_prog ? sel_flag(flag_q, relay_code)
                                     : ~flag_q[drive_pkg::C_FLT];
  logic [N_OUT-1:0] out_d;  // Per-output selection

  // Each output decodes its own code
  for (genvar g = 0; g < N_OUT; g++) begin : g_out
    assign out_d[g] = sel_flag(flag_q, osel_q[4*g +: 4]);
  end

  // Reset leaves the changeover relay on its fault side
  // Fault contact is always the inverse of the healthy one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_out             <= '0;
      relay_healthy_contact <= 1'b0;
      relay_fault_contact   <= 1'b1;
    end else begin
      relay_out             <= out_d;
      relay_healthy_contact <= healthy_d;
      relay_fault_contact   <= ~healthy_d;
    end
  end

  // ==========================================================
  // Monitor outputs
  // ==========================================================
  logic [7:0] mon_q [3];   // Voltage, current, pulse

  // Three independent selectors
  // Each selector reads its own four-bit code
  for (genvar m = 0; m < 3; m++) begin : g_mon
    monitor_sel u_mon (
      .clk   (pclk),
      .rst_n (presetn),
      .code  (msel_q[4*m +: 4]),
      .meas  (meas),
      .mon_q (mon_q[m])
    );
  end

  // Fixed slot order: voltage, current, pulse
  assign voltage_monitor_out = mon_q[0];
  assign current_monitor_out = mon_q[1];
  assign pulse_monitor_out   = mon_q[2];

  // ==========================================================
  // Interrupts
  // ==========================================================
  // Status records each rising flag until cleared
  wire [NC-1:0] rise = flag_d & ~flag_q;                  // Flag rising
  // Write-one-to-clear, only on a completed write
  wire [NC-1:0] clr  = (wr_fire && hit_ista) ? pwdata[NC-1:0] : '0;

  // Sticky status, set wins over clear
  // Interrupt uses the next status, rising with the bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ista_q <= '0;
      irq    <= 1'b0;
    end else begin
      ista_q <= (ista_q & ~clr) | rise;
      irq    <= |(((ista_q & ~clr) | rise) & imsk_q);
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  // Checks run on the bus clock, paused in reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Flags, one cycle behind their conditions
  a_run_flag: assert property (flag_q[0] == $past(pin_s.motor_run))
    else $error("run flag wrong");
  a_spr_flag: assert property ((fdiff <= tol) |=> flag_q[1])
    else $error("setpoint flag missing");
  a_abv_flag: assert property ((meas.fout > thr_q[0]) |=> flag_q[2])
    else $error("above flag missing");
  a_ovl_flag: assert property ((meas.load > thr_q[4]) |=> flag_q[3])
    else $error("overload flag missing");
  a_pid_flag: assert property ((meas.pid_err > thr_q[5]) |=> flag_q[4])
    else $error("pid flag missing");
  a_flt_flag: assert property (pins.fault [*3] |=> flag_q[5])
    else $error("fault flag missing");
  a_bnd_flag: assert property ((meas.fout < blo) |=> !flag_q[6])
    else $error("band flag outside band");
  a_mnl_flag: assert property (pins.mains_dip [*3] |=> flag_q[8])
    else $error("mains flag missing");
  a_lsp_flag: assert property (pins.undervolt [*3] |=> flag_q[9])
    else $error("supply flag missing");
  a_hrs_flag: assert property ((meas.run_hours > thr_q[6]) |=> flag_q[11])
    else $error("run hours flag missing");
  a_pon_flag: assert property ((meas.on_hours > thr_q[7]) |=> flag_q[12])
    else $error("on hours flag missing");
  a_mht_flag: assert property ((meas.thermal > thr_q[8]) |=> flag_q[13])
    else $error("heat flag missing");

  // Changeover relay and programmable outputs
  a_fault_relay: assert property (!relay_prog && flag_q[5] |=>
    relay_fault_contact && !relay_healthy_contact)
    else $error("fault relay not on fault side");
  a_relay_prog: assert property (relay_prog && !$past(relay_prog) |=>
    relay_healthy_contact == sel_flag($past(flag_q), $past(relay_code)))
    else $error("relay ignores its code");
  a_bad_code: assert property (osel_q[3:0] == 4'hF |=> !relay_out[0])
    else $error("unsupported code drives output");
  a_flag_drop: assert property (!pins.motor_run [*3] |=> !flag_q[0])
    else $error("run flag held");

  // Contacts, selection, bus and status
  a_contacts_inv: assert property (relay_fault_contact != relay_healthy_contact)
    else $error("contacts not complementary");
  a_out_select: assert property (osel_q[3:0] == 4'h0 |=>
    relay_out[0] == $past(flag_q[0]))
    else $error("output ignores its code");
  a_status_set: assert property (rise[0] |=> ista_q[0])
    else $error("status bit lost");
  a_irq_masked: assert property (imsk_q == '0 |=> !irq)
    else $error("masked interrupt raised");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_mon_volt: assert property (msel_q[3:0] == 4'h4 |=>
    voltage_monitor_out == $past(meas.volt[15:8]))
    else $error("voltage monitor wrong");

  // Main scenarios
  c_run_out: cover property (osel_q[3:0] == 4'h0 ##1 relay_out[0]);
  c_fault:   cover property (!relay_prog && flag_q[5] ##1 relay_fault_contact);
  c_irq:     cover property (!irq ##1 irq);
  c_bus_err: cover property (pslverr);
  c_prog:    cover property (relay_prog && relay_healthy_contact);

endmodule : drive_status_output_select

`default_nettype wire

// ===== testbench/relay_load.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Far side: relay coils, lamps and the fault changeover
// ==========================================================
module relay_load #(
  parameter int N = 2                 // Programmable relays
) (
  input  wire logic [N-1:0] coil,     // Relay coils
  input  wire logic         healthy,  // Healthy coil
  input  wire logic         faulty,   // Fault coil
  output logic      [N-1:0] lamp,     // Lamps lit
  output logic              alarm     // Common closed to fault side
);
  assign lamp  = coil;
  assign alarm = faulty & !healthy;
endmodule : relay_load
`default_nettype wire

// ===== testbench/test_drive_status_output_select.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module test_drive_status_output_select;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} note_t;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;  // Full compare mask
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, vm, cm, pm;
  logic [31:0] pwdata, prdata;
  logic        hc, fc, irq, alarm, f;
  logic [1:0]  relay, lamp;
  drive_pkg::drive_pins_t pins;
  drive_pkg::drive_meas_t meas;
  note_t       notes[$], nt;
  int          n_mismatch, compares, cyc;
  byte codes[12] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 11, 12, 13};
  byte bad[4] = '{7, 10, 14, 15};

  drive_status_output_select #(.N_OUT(2)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .meas(meas),
    .relay_out(relay), .relay_healthy_contact(hc), .relay_fault_contact(fc),
    .voltage_monitor_out(vm), .current_monitor_out(cm), .pulse_monitor_out(pm),
    .irq(irq));
  relay_load #(.N(2)) rl (.coil(relay), .healthy(hc), .faulty(fc), .lamp(lamp),
    .alarm(alarm));

  // ==========================================================
  // Clock, timeout and result watcher
  // ==========================================================
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // Oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      nt = notes.pop_front();
      `CHK("prdata", nt.d, prdata & nt.m);
      `CHK("pslverr", nt.e, pslverr);
    end
  end

  task chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // APB transfer, request held until pready
  task apb(logic w, logic [7:0] a, logic [31:0] wd, logic [31:0] ed, logic [31:0] em,
           logic ee);
    int n;
    n = 0;
    notes.push_back('{ed, em, ee});
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) n_mismatch++;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task wr(logic [7:0] a, logic [31:0] d);
    apb(1, a, d, 0, 0, 0);
  endtask : wr
  // Makes the condition behind code c true or false
  task drive(logic [3:0] c, logic on);
    drive_pkg::drive_pins_t p;
    drive_pkg::drive_meas_t m;
    logic [15:0] v;
    p = '0;
    m = '0;
    v = 16'($urandom_range(65535, 1));
    case (c)
      0: p.motor_run = on;
      1: m.fset = on ? 16'h0 : 16'h1;
      2: m.fout = on ? v : 16'h0;
      3: m.load = on ? v : 16'h0;
      4: m.pid_err = on ? v : 16'h0;
      5: p.fault = on;
      6: m.fout = on ? 16'h0 : v;
      8: p.mains_dip = on;
      9: p.undervolt = on;
      11: m.run_hours = on ? v : 16'h0;
      12: m.on_hours = on ? v : 16'h0;
      default: m.thermal = on ? v : 16'h0;
    endcase
    pins <= p;
    meas <= m;
  endtask : drive
  function logic [7:0] pick(logic [3:0] c);
    case (c)
      0, 3: return meas.fout[15:8];
      1: return meas.current[15:8];
      2: return meas.torque[15:8];
      4: return meas.volt[15:8];
      5: return meas.power[15:8];
      6: return meas.thermal[15:8];
      7: return meas.ramp[15:8];
      default: return 8'h00;
    endcase
  endfunction : pick

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pins = '0;
    meas = '0;
    void'($urandom(12));
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(0, drive_pkg::A_CTRL, 0, 32'h00000050, ALL, 0);
    apb(0, drive_pkg::A_OSEL, 0, 32'h000000FF, ALL, 0);
    apb(0, 8'h40, 0, 0, ALL, 1);
    $display("test reset done");
    foreach (codes[i]) begin
      wr(drive_pkg::A_OSEL, {24'h0, bad[i % 4][3:0], codes[i][3:0]});
      for (int on = 1; on >= 0; on--) begin
        drive(codes[i][3:0], on[0]);
        repeat (6) @(posedge pclk);
        f = (codes[i] == 5) && on[0];
        `CHK("alarm", f, alarm);
        `CHK("lamp", {1'b0, on[0]}, lamp);
        apb(0, drive_pkg::A_OUTS, 0, {28'h0, f, !f, 1'b0, on[0]}, 32'hF, 0);
      end
    end
    $display("test codes done");
    wr(drive_pkg::A_ISTA, 32'h0000FFFF);
    wr(drive_pkg::A_IMSK, 32'h00000001);
    drive(0, 1);
    repeat (6) @(posedge pclk);
    `CHK("irq", 1, irq);
    wr(drive_pkg::A_IMSK, 32'h00000000);
    repeat (2) @(posedge pclk);
    `CHK("irq", 0, irq);
    wr(drive_pkg::A_CTRL, 32'h00000001);
    apb(0, drive_pkg::A_OUTS, 0, 32'h4, 32'hF, 0);
    drive(0, 0);
    repeat (6) @(posedge pclk);
    apb(0, drive_pkg::A_OUTS, 0, 32'h8, 32'hF, 0);
    $display("test irq and relay mode done");
    for (int c = 0; c < 9; c++) begin
      meas <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      wr(drive_pkg::A_MSEL, {20'h0, 4'((c + 2) % 9), 4'((c + 1) % 9), c[3:0]});
      repeat (3) @(posedge pclk);
      `CHK("vmon", pick(c[3:0]), vm);
      `CHK("cmon", pick(4'((c + 1) % 9)), cm);
      `CHK("pmon", pick(4'((c + 2) % 9)), pm);
    end
    $display("test monitors done");
    print_verdict();
  end
endmodule : test_drive_status_output_select
`default_nettype wire
